// ---- rtl/sesfe_cfg.svh ----
// Constants for the two-wire EEPROM slave front end and its bus master
`ifndef SESFE_CFG_SVH
`define SESFE_CFG_SVH
`define SESFE_ADDR_W     13
`define SESFE_MASK_4K    13'h0FFF
`define SESFE_MASK_8K    13'h1FFF
`define SESFE_QBASE_4K   13'h0C00
`define SESFE_QBASE_8K   13'h1800
`define SESFE_DEV_CODE   4'hA
`define SESFE_LAST_BIT   4'h8
`define SESFE_ACK_BIT    4'h9
`define SESFE_PROG_MS    5
`define SESFE_CLK_KHZ    125000
`define SESFE_CLK_NS     8
`define SESFE_QTR_NS     128
`define SESFE_PCNT_W     20
`define SESFE_REG_CMD    4'h0
`define SESFE_REG_STAT   4'h4
`define SESFE_CMD_START  8
`define SESFE_CMD_STOP   9
`define SESFE_CMD_REC    10
`define SESFE_RESP_OKAY  2'h0
`define SESFE_RESP_SLVERR 2'h2
`endif

// ---- rtl/sesfe_pkg.sv ----
// Types shared by both ends of the two-wire link
`include "sesfe_cfg.svh"
package sesfe_pkg;
  typedef enum logic [2:0] {
    DEV_IDLE, DEV_ADDR, DEV_HI, DEV_LO, DEV_DATA, DEV_WAIT, DEV_PROG
  } sesfe_dev_state_type;
  typedef enum logic [2:0] {
    MST_IDLE, MST_START, MST_BIT, MST_STOP, MST_REC
  } sesfe_mst_state_type;
  typedef logic [`SESFE_ADDR_W-1:0] sesfe_addr_type;
endpackage

// ---- rtl/sesfe_link_if.sv ----
// Two-wire link between the bus master and the EEPROM slave end
`timescale 1ns/10ps
interface sesfe_link_if;
  logic scl;
  logic sda;
  logic dev_sda_oe;
  logic dev_sda_o;
  logic mst_sda_oe;
  logic mst_sda_o;
  // Pulled-up wire: low whenever any enabled driver drives low
  assign sda = !((dev_sda_oe && !dev_sda_o) || (mst_sda_oe && !mst_sda_o));
  modport dev (input scl, input sda, output dev_sda_oe, output dev_sda_o);
  modport mst (output scl, input sda, output mst_sda_oe, output mst_sda_o);
endinterface

// ---- rtl/sesfe_dev.sv ----
// EEPROM slave end: bus decode, byte-write sequencing, programming timer
`timescale 1ns/10ps
`include "sesfe_cfg.svh"
// Operation
// - Data line only pulled low or released
// - Unconnected select inputs count as zero
// - Write guard protects whole or top quarter
// - Array of 4K or 8K bytes
// - Master makes clock, Start and Stop
// - Master starts only on an idle bus
// - Data change while clock high is Start/Stop
// - One clock pulse per bit, sampled high
// - Ignore the bus until a Start
// - Rising data with clock high is Stop
// - Receiver acknowledges by holding data low
// - Any Start aborts; master may clock nine
// - Standby at power-up, after Stop, after programming
// - Address accepted only if upper nibble 1010
// - Next three bits match select inputs
// - Last address bit: one read, zero write
// - Matching address acknowledged on ninth clock
// - Byte write: address, two address bytes, data, Stop
// - Acknowledge address and data; Stop starts programming
// - No response while programming
// - Self-timed programming, at most 5 ms
module sesfe_dev
  import sesfe_pkg::*;
#(
  parameter bit          BIG_ARRAY   = 1'b1,
  parameter bit          QUARTER_WP  = 1'b0,
  parameter int unsigned PROG_CYCLES = `SESFE_PROG_MS * `SESFE_CLK_KHZ
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          clk_en,
  sesfe_link_if.dev          link,
  input  wire logic [2:0]    device_select_pins,
  input  wire logic [2:0]    select_driven,
  input  wire logic          write_guard,
  input  wire logic          guard_driven,
  output sesfe_pkg::sesfe_addr_type pointer,
  output logic [7:0]         stored_byte,
  output logic               prog_busy,
  output logic               standby
);
  import sesfe_pkg::*;

  localparam int unsigned PCYC = (PROG_CYCLES < 1) ? 1 : PROG_CYCLES;

  // Pin samples: {scl, sda, select[2:0], select_driven[2:0], guard, guard_driven}
  logic [9:0]                 s1_ff;
  logic [9:0]                 s2_ff;
  logic [1:0]                 prev_ff;
  sesfe_dev_state_type        state_ff;
  logic [3:0]                 cnt_ff;
  logic [7:0]                 shift_ff;
  logic [7:0]                 hi_ff;
  logic [7:0]                 data_ff;
  sesfe_addr_type             ptr_ff;
  logic                       oe_ff;
  logic                       sda_o_ff;
  logic [`SESFE_PCNT_W-1:0]   pcnt_ff;
  logic                       busy_ff;
  logic                       standby_ff;
  logic                       pwrup_ff;
  logic [7:0]                 rd_ff;
  logic [7:0]                 mem [0:(1<<`SESFE_ADDR_W)-1];

  logic                       scl_s;
  logic                       sda_s;
  logic                       scl_rise;
  logic                       scl_fall;
  logic                       start_c;
  logic                       stop_c;
  logic [2:0]                 sel_eff;
  logic                       guard_eff;
  sesfe_addr_type             mask_c;
  sesfe_addr_type             qbase_c;
  logic                       protected_c;
  logic                       match_c;
  logic                       ack_c;
  logic                       prog_go;
  logic                       toggle_c;
  sesfe_dev_state_type        next_c;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_ff   <= 10'h3FF;
      s2_ff   <= 10'h3FF;
      prev_ff <= 2'h3;
    end else if (clk_en) begin
      s1_ff   <= {link.scl, link.sda, device_select_pins, select_driven, write_guard, guard_driven};
      s2_ff   <= s1_ff;
      prev_ff <= s2_ff[9:8];
    end
  end

  assign scl_s     = s2_ff[9];
  assign sda_s     = s2_ff[8];
  assign scl_rise  = scl_s & ~prev_ff[1];
  assign scl_fall  = ~scl_s & prev_ff[1];
  assign start_c   = scl_s & prev_ff[1] & prev_ff[0] & ~sda_s;
  assign stop_c    = scl_s & prev_ff[1] & ~prev_ff[0] & sda_s;
  assign toggle_c  = (s2_ff[9:8] != prev_ff);
  assign sel_eff   = s2_ff[7:5] & s2_ff[4:2];
  assign guard_eff = s2_ff[1] & s2_ff[0];
  assign mask_c    = BIG_ARRAY ? `SESFE_MASK_8K : `SESFE_MASK_4K;
  assign qbase_c   = BIG_ARRAY ? `SESFE_QBASE_8K : `SESFE_QBASE_4K;
  assign protected_c = guard_eff & (~QUARTER_WP | (ptr_ff >= qbase_c));
  assign match_c   = (shift_ff[7:4] == `SESFE_DEV_CODE)
                   & (shift_ff[3:1] == sel_eff);
  assign prog_go   = stop_c & (state_ff == DEV_WAIT) & ~protected_c;

  always_comb begin
    ack_c  = 1'b0;
    next_c = DEV_IDLE;
    case (state_ff)
      DEV_ADDR: begin
        ack_c  = match_c;
        next_c = (match_c && !shift_ff[0]) ? DEV_HI : DEV_IDLE;
      end
      DEV_HI: begin
        ack_c  = 1'b1;
        next_c = DEV_LO;
      end
      DEV_LO: begin
        ack_c  = 1'b1;
        next_c = DEV_DATA;
      end
      DEV_DATA: begin
        ack_c  = 1'b1;
        next_c = DEV_WAIT;
      end
      DEV_WAIT: begin
        next_c = DEV_WAIT;
      end
      default: begin
        next_c = DEV_IDLE;
      end
    endcase
  end

  // Bus sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= DEV_IDLE;
      cnt_ff   <= 4'h0;
      shift_ff <= 8'h00;
      oe_ff    <= 1'b0;
    end else if (clk_en) begin
      if (state_ff == DEV_PROG) begin
        oe_ff <= 1'b0;
        if (!busy_ff) begin
          state_ff <= DEV_IDLE;
        end
      end else if (start_c) begin
        state_ff <= DEV_ADDR;
        cnt_ff   <= 4'h0;
        oe_ff    <= 1'b0;
      end else if (stop_c) begin
        state_ff <= prog_go ? DEV_PROG : DEV_IDLE;
        cnt_ff   <= 4'h0;
        oe_ff    <= 1'b0;
      end else if (state_ff != DEV_IDLE) begin
        if (scl_rise && cnt_ff < `SESFE_LAST_BIT) begin
          shift_ff <= {shift_ff[6:0], sda_s};
          cnt_ff   <= cnt_ff + 4'h1;
        end else if (scl_fall && cnt_ff == `SESFE_LAST_BIT) begin
          oe_ff  <= ack_c;
          cnt_ff <= `SESFE_ACK_BIT;
        end else if (scl_fall && cnt_ff == `SESFE_ACK_BIT) begin
          oe_ff    <= 1'b0;
          cnt_ff   <= 4'h0;
          state_ff <= next_c;
        end
      end
    end
  end

  // Address and data capture at the end of the two address bytes and the data byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_ff   <= 8'h00;
      data_ff <= 8'h00;
      ptr_ff  <= '0;
    end else if (clk_en && scl_fall && cnt_ff == `SESFE_LAST_BIT && !start_c && !stop_c) begin
      case (state_ff)
        DEV_HI:   hi_ff   <= shift_ff;
        DEV_LO:   ptr_ff  <= {hi_ff[`SESFE_ADDR_W-9:0], shift_ff} & mask_c;
        DEV_DATA: data_ff <= shift_ff;
        default:  hi_ff   <= hi_ff;
      endcase
    end
  end

  // Self-timed programming cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pcnt_ff <= '0;
      busy_ff <= 1'b0;
    end else if (clk_en) begin
      if (prog_go && state_ff != DEV_PROG) begin
        pcnt_ff <= `SESFE_PCNT_W'(PCYC);
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        pcnt_ff <= pcnt_ff - `SESFE_PCNT_W'(1);
        busy_ff <= (pcnt_ff != `SESFE_PCNT_W'(1));
      end
    end
  end

  // Storage array, written once per programming cycle
  always_ff @(posedge aclk) begin
    if (clk_en) begin
      if (prog_go && state_ff != DEV_PROG) begin
        mem[ptr_ff] <= data_ff;
      end
      rd_ff <= mem[ptr_ff];
    end
  end

  // Low-power standby tracking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      standby_ff <= 1'b1;
      pwrup_ff   <= 1'b1;
    end else if (clk_en) begin
      if (pwrup_ff && toggle_c) begin
        pwrup_ff   <= 1'b0;
        standby_ff <= 1'b0;
      end else if ((stop_c && !prog_go && state_ff != DEV_PROG)
                   || (busy_ff && pcnt_ff == `SESFE_PCNT_W'(1))) begin
        standby_ff <= 1'b1;
      end else if (start_c && state_ff != DEV_PROG) begin
        standby_ff <= 1'b0;
      end
    end
  end

  // Open-drain: the pin value is held low, only the enable moves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sda_o_ff <= 1'b0;
    end else if (clk_en) begin
      sda_o_ff <= 1'b0;
    end
  end

  assign link.dev_sda_oe = oe_ff;
  assign link.dev_sda_o  = sda_o_ff;
  assign pointer         = ptr_ff;
  assign stored_byte     = rd_ff;
  assign prog_busy       = busy_ff;
  assign standby         = standby_ff;
endmodule

// ---- rtl/sesfe_mst.sv ----
// Two-wire bus master with an AXI4-Lite command and status port
`timescale 1ns/10ps
`include "sesfe_cfg.svh"
module sesfe_mst
  import sesfe_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  sesfe_link_if.mst        link,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import sesfe_pkg::*;

  localparam int QTR_CYC = (`SESFE_QTR_NS / `SESFE_CLK_NS < 1) ? 1 : `SESFE_QTR_NS / `SESFE_CLK_NS;

  sesfe_mst_state_type state_ff;
  logic [7:0]          qcnt_ff;
  logic [1:0]          q_ff;
  logic [3:0]          bit_ff;
  logic [7:0]          sh_ff;
  logic [8:0]          rx_ff;
  logic                stop_ff;
  logic                scl_ff;
  logic                oe_ff;
  logic                sda_o_ff;
  logic [1:0]          sda_sync_ff;
  logic                awready_ff;
  logic                bvalid_ff;
  logic [1:0]          bresp_ff;
  logic                arready_ff;
  logic                rvalid_ff;
  logic [31:0]         rdata_ff;
  logic [1:0]          rresp_ff;
  logic                wr_take;
  logic                go_c;
  logic                tick_c;

  assign wr_take = awready_ff;
  assign go_c    = wr_take && s_axi_awaddr == `SESFE_REG_CMD && state_ff == MST_IDLE && s_axi_wstrb[1:0] == 2'h3;
  assign tick_c  = (qcnt_ff == 8'(QTR_CYC - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sda_sync_ff <= 2'h3;
    end else if (clk_en) begin
      sda_sync_ff <= {sda_sync_ff[0], link.sda};
    end
  end

  // Bit engine in quarter-period steps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= MST_IDLE;
      qcnt_ff  <= 8'h00;
      q_ff     <= 2'h0;
      bit_ff   <= 4'h0;
      sh_ff    <= 8'h00;
      rx_ff    <= 9'h000;
      stop_ff  <= 1'b0;
      scl_ff   <= 1'b1;
      oe_ff    <= 1'b0;
      sda_o_ff <= 1'b0;
    end else if (clk_en) begin
      if (state_ff == MST_IDLE) begin
        qcnt_ff <= 8'h00;
        q_ff    <= 2'h0;
        bit_ff  <= 4'h0;
        if (go_c) begin
          sh_ff   <= s_axi_wdata[7:0];
          stop_ff <= s_axi_wdata[`SESFE_CMD_STOP];
          if (s_axi_wdata[`SESFE_CMD_REC]) begin
            state_ff <= MST_REC;
          end else if (s_axi_wdata[`SESFE_CMD_START]) begin
            state_ff <= MST_START;
          end else begin
            state_ff <= MST_BIT;
          end
        end
      end else if (!tick_c) begin
        qcnt_ff <= qcnt_ff + 8'h01;
      end else begin
        qcnt_ff <= 8'h00;
        q_ff    <= q_ff + 2'h1;
        case (state_ff)
          MST_START: begin
            if (q_ff == 2'h0) oe_ff <= 1'b0;
            if (q_ff == 2'h1) scl_ff <= 1'b1;
            if (q_ff == 2'h2) oe_ff <= 1'b1;
            if (q_ff == 2'h3) begin
              scl_ff   <= 1'b0;
              state_ff <= MST_BIT;
            end
          end
          MST_BIT: begin
            if (q_ff == 2'h0) oe_ff <= (bit_ff < `SESFE_LAST_BIT) && !sh_ff[7];
            if (q_ff == 2'h1) scl_ff <= 1'b1;
            if (q_ff == 2'h2) rx_ff <= {rx_ff[7:0], sda_sync_ff[1]};
            if (q_ff == 2'h3) begin
              scl_ff <= 1'b0;
              sh_ff  <= {sh_ff[6:0], 1'b0};
              bit_ff <= bit_ff + 4'h1;
              if (bit_ff == `SESFE_LAST_BIT) begin
                state_ff <= stop_ff ? MST_STOP : MST_IDLE;
              end
            end
          end
          MST_STOP: begin
            if (q_ff == 2'h0) oe_ff <= 1'b1;
            if (q_ff == 2'h1) scl_ff <= 1'b1;
            if (q_ff == 2'h2) oe_ff <= 1'b0;
            if (q_ff == 2'h3) state_ff <= MST_IDLE;
          end
          default: begin
            if (q_ff == 2'h0) oe_ff <= 1'b0;
            if (q_ff == 2'h1) scl_ff <= 1'b1;
            if (q_ff == 2'h2 && sda_sync_ff[1]) state_ff <= MST_IDLE;
            if (q_ff == 2'h3) begin
              scl_ff <= 1'b0;
              bit_ff <= bit_ff + 4'h1;
              if (bit_ff == `SESFE_LAST_BIT) state_ff <= MST_IDLE;
            end
          end
        endcase
      end
    end
  end

  // Write channel: address and data taken together, then a response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `SESFE_RESP_OKAY;
    end else if (clk_en) begin
      awready_ff <= s_axi_awvalid && s_axi_wvalid && !awready_ff && !bvalid_ff;
      if (wr_take) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= (s_axi_awaddr == `SESFE_REG_CMD) ? `SESFE_RESP_OKAY : `SESFE_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Read channel: status shows busy, acknowledge and last received byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= `SESFE_RESP_OKAY;
    end else if (clk_en) begin
      arready_ff <= s_axi_arvalid && !arready_ff && !rvalid_ff;
      if (arready_ff) begin
        rvalid_ff <= 1'b1;
        if (s_axi_araddr == `SESFE_REG_STAT) begin
          rdata_ff <= {22'h00_0000, rx_ff, state_ff != MST_IDLE};
          rresp_ff <= `SESFE_RESP_OKAY;
        end else if (s_axi_araddr == `SESFE_REG_CMD) begin
          rdata_ff <= {24'h00_0000, sh_ff};
          rresp_ff <= `SESFE_RESP_OKAY;
        end else begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= `SESFE_RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign link.scl        = scl_ff;
  assign link.mst_sda_oe = oe_ff;
  assign link.mst_sda_o  = sda_o_ff;
  assign s_axi_awready   = awready_ff;
  assign s_axi_wready    = awready_ff;
  assign s_axi_bvalid    = bvalid_ff;
  assign s_axi_bresp     = bresp_ff;
  assign s_axi_arready   = arready_ff;
  assign s_axi_rvalid    = rvalid_ff;
  assign s_axi_rdata     = rdata_ff;
  assign s_axi_rresp     = rresp_ff;
endmodule

// ---- dv/sesfe_assertions.sv ----
// Link checker for the two-wire EEPROM slave end and its master
`timescale 1ns/10ps
module sesfe_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe,
  input wire logic dev_sda_o,
  input wire logic mst_sda_oe,
  input wire logic mst_sda_o
);
  logic       scl_ff;
  logic       sda_ff;
  logic       frame_ff;
  logic [3:0] rise_ff;
  wire        start_w = scl && scl_ff && sda_ff && !sda;
  wire        stop_w  = scl && scl_ff && !sda_ff && sda;
  wire        rise_w  = scl && !scl_ff;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    scl_ff <= scl;
    sda_ff <= sda;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || stop_w) begin
      frame_ff <= 1'b0;
    end else if (start_w) begin
      frame_ff <= 1'b1;
    end
  end
  // Clock pulses since the last Start, 1 to 9 for each byte
  always_ff @(posedge aclk) begin
    if (!aresetn || start_w) begin
      rise_ff <= 4'h0;
    end else if (rise_w) begin
      rise_ff <= (rise_ff == 4'h9) ? 4'h1 : rise_ff + 4'h1;
    end
  end
  a_only_pull_low: assert property ((dev_sda_oe -> !dev_sda_o) && (mst_sda_oe -> !mst_sda_o))
    else $error("data line driven high");
  a_ack_scl_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("slave changed data while clock high");
  a_quiet_idle: assert property (dev_sda_oe |-> frame_ff)
    else $error("slave drove data outside a frame");
  a_ack_ninth: assert property (rise_w && dev_sda_oe |-> rise_ff == 4'h8)
    else $error("slave acknowledge not on ninth clock");
  a_ack_spans: assert property ($rose(dev_sda_oe) |-> dev_sda_oe throughout (##[1:100] $fell(scl)))
    else $error("acknowledge dropped before clock pulse ended");
  a_ack_release: assert property (dev_sda_oe && $fell(scl) |-> ##[1:8] !dev_sda_oe)
    else $error("acknowledge held past its clock");
  a_stop_idle: assert property (stop_w |-> !dev_sda_oe)
    else $error("slave driving at stop");
  a_mst_release: assert property (rise_w && frame_ff && rise_ff == 4'h8 |-> !mst_sda_oe)
    else $error("master held data in acknowledge slot");
endmodule

// ---- dv/serial_eeprom_slave_front_end_bench.sv ----
// Bench: AXI4-Lite driven master talking to the EEPROM slave end
`timescale 1ns/10ps
module serial_eeprom_slave_front_end_bench;
  import sesfe_pkg::*;
  typedef struct {string nm; logic [31:0] exp; logic [31:0] msk;} sesfe_note_type;
  logic           aclk;
  logic           aresetn = 1'b0;
  logic           clk_en = 1'b1;
  logic           probe = 1'b0;
  logic [2:0]     device_select_pins = 3'h0;
  logic [2:0]     select_driven = 3'h7;
  logic           write_guard = 1'b0;
  logic           guard_driven = 1'b1;
  sesfe_addr_type pointer;
  logic [7:0]     stored_byte;
  logic           prog_busy, standby;
  logic [3:0]     s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0]    s_axi_wdata = 32'h0000_0000;
  logic           s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic           s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic           s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]     s_axi_bresp, s_axi_rresp;
  logic [31:0]    s_axi_rdata, got;
  logic [15:0]    rnd = 16'h002d;
  sesfe_note_type notes[$];
  sesfe_note_type cur;
  int             n_mismatch = 0;
  int             checks = 0;
  sesfe_link_if sesfe_link_if_inst ();
  sesfe_dev #(.BIG_ARRAY(1'b1), .QUARTER_WP(1'b1), .PROG_CYCLES(2000)) sesfe_dev_inst (.aclk, .aresetn, .clk_en,
    .link(sesfe_link_if_inst), .device_select_pins, .select_driven, .write_guard, .guard_driven, .pointer,
    .stored_byte, .prog_busy, .standby);
  sesfe_mst sesfe_mst_inst (.aclk, .aresetn, .clk_en, .link(sesfe_link_if_inst), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  sesfe_assertions sesfe_assertions_inst (.aclk, .aresetn, .scl(sesfe_link_if_inst.scl),
    .sda(sesfe_link_if_inst.sda), .dev_sda_oe(sesfe_link_if_inst.dev_sda_oe),
    .dev_sda_o(sesfe_link_if_inst.dev_sda_o), .mst_sda_oe(sesfe_link_if_inst.mst_sda_oe),
    .mst_sda_o(sesfe_link_if_inst.mst_sda_o));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  function automatic logic [15:0] lfsr_next(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] pk(logic sb, logic bz, logic [7:0] sv, logic [12:0] pt);
    return {9'h000, sb, bz, sv, pt};
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic axi_wr(logic [3:0] a, logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axi_rd(logic [3:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // One byte on the link; nk is the expected acknowledge bit (1 = none)
  task automatic xfer(logic [10:0] c, logic nk);
    logic [31:0] st;
    axi_wr(4'h0, {21'h00_0000, c});
    st = 32'h0000_0001;
    while (st[0]) axi_rd(4'h4, st);
    notes.push_back('{"ack", {22'h00_0000, c[7:0], nk, 1'b0}, 32'h0000_03ff});
    axi_rd(4'h4, st);
  endtask
  task automatic look(string nm, logic [31:0] e, logic [31:0] m);
    notes.push_back('{nm, e, m});
    probe <= 1'b1;
    @(posedge aclk);
    probe <= 1'b0;
    @(posedge aclk);
  endtask
  // Byte write frame; pg says whether programming must start, es is the byte then stored
  task automatic bw(logic [2:0] s, logic [12:0] ad, logic [7:0] d, logic pg, logic [7:0] es);
    int i;
    rnd = lfsr_next(rnd);
    xfer({3'b001, 4'ha, s, 1'b0}, 1'b0);
    xfer({3'b000, rnd[2:0], ad[12:8]}, 1'b0);
    xfer({3'b000, ad[7:0]}, 1'b0);
    xfer({3'b010, d}, 1'b0);
    look("after stop", pk(!pg, pg, 8'h00, ad), 32'h0060_1fff);
    if (pg) xfer({3'b011, 4'ha, s, 1'b0}, 1'b1);
    for (i = 0; i < 5000 && prog_busy !== 1'b0; i++) @(posedge aclk);
    look("settled", pk(1'b1, 1'b0, es, ad), 32'h007f_ffff);
  endtask
  always @(posedge aclk) begin
    if (notes.size() != 0 && (probe || (s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready))) begin
      cur = notes.pop_front();
      got = probe ? pk(standby, prog_busy, stored_byte, pointer) : s_axi_bvalid ? {30'h0, s_axi_bresp} : s_axi_rdata;
      checks++;
      if ((got & cur.msk) !== cur.exp) begin
        $display("[ERR] %s expected %h seen %h", cur.nm, cur.exp, got & cur.msk);
        n_mismatch++;
      end
      // Unmapped reads must answer with a slave error, mapped ones with okay
      if (s_axi_rvalid && !probe && s_axi_rresp !== ((cur.nm == "bad rd") ? 2'h2 : 2'h0)) begin
        $display("[ERR] rresp expected %h seen %h", (cur.nm == "bad rd") ? 2'h2 : 2'h0, s_axi_rresp);
        n_mismatch++;
      end
    end
  end
  initial begin
    #(90000 * 8);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    logic [31:0] st;
    logic [2:0]  eff;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    look("reset", pk(1'b1, 1'b0, 8'h00, 13'h0000), 32'h0060_1fff);
    notes.push_back('{"bad rd", 32'h0000_0000, 32'hffff_ffff});
    axi_rd(4'h8, st);
    notes.push_back('{"bad wr", 32'h0000_0002, 32'h0000_0003});
    axi_wr(4'h8, 32'h0000_0000);
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr_next(rnd);
      device_select_pins <= rnd[2:0];
      select_driven <= rnd[5:3];
      eff = rnd[2:0] & rnd[5:3];
      repeat (4) @(posedge aclk);
      bw(eff, {1'b0, rnd[11:0]}, rnd[15:8], 1'b1, rnd[15:8]);
    end
    xfer({3'b011, 4'hb, eff, 1'b0}, 1'b1);
    xfer({3'b011, 4'ha, ~eff, 1'b0}, 1'b1);
    xfer({3'b011, 4'ha, eff, 1'b1}, 1'b0);
    look("idle", pk(1'b1, 1'b0, 8'h00, 13'h0000), 32'h0060_0000);
    bw(eff, 13'h1800, 8'h5a, 1'b1, 8'h5a);
    write_guard <= 1'b1;
    repeat (4) @(posedge aclk);
    bw(eff, 13'h1800, 8'ha5, 1'b0, 8'h5a);
    bw(eff, 13'h17ff, 8'h3c, 1'b1, 8'h3c);
    guard_driven <= 1'b0;
    repeat (4) @(posedge aclk);
    bw(eff, 13'h1fff, 8'hc3, 1'b1, 8'hc3);
    xfer({3'b001, 4'ha, eff, 1'b0}, 1'b0);
    xfer(11'h001, 1'b0);
    axi_wr(4'h0, 32'h0000_0400);
    st = 32'h0000_0001;
    while (st[0]) axi_rd(4'h4, st);
    bw(eff, 13'h0123, 8'h77, 1'b1, 8'h77);
    wrap_up();
  end
endmodule
